// [bench/host_link_model.sv]
// host computer model: sends command frames and gathers reply bytes
// assumes the framer hands bytes as single-cycle pulses on one clock
`timescale 1ns/10ps
`default_nettype none
module host_link_model (
	// clock
	input wire logic pclk,
	// frame bytes toward the block
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_end,
	output logic rx_err,
	// reply bytes from the block
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready
);
	typedef wdt_cmd_pkg::byte_t bq_t[$];
	bq_t got;
	logic slow = 1'b0;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_end = 1'b0;
		rx_err = 1'b0;
		tx_ready = 1'b0;
	end
	// slow mode takes a reply byte only every other cycle, to stall the sender
	always @(posedge pclk) begin
		tx_ready <= slow ? ~tx_ready : 1'b1;
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
			got.push_back(tx_data);
	end
	// whole 8-bit characters; idle data shows the inverse of the last byte
	task automatic send(input bq_t f, input bit err);
		foreach (f[i]) begin
			@(posedge pclk);
			rx_valid <= 1'b1;
			rx_data <= f[i];
		end
		@(posedge pclk);
		rx_valid <= 1'b0;
		rx_data <= ~f[f.size()-1];
		rx_err <= err;
		if (err) begin
			@(posedge pclk);
			rx_err <= 1'b0;
		end
		rx_end <= 1'b1;
		@(posedge pclk);
		rx_end <= 1'b0;
	endtask
endmodule
`default_nettype wire

// [bench/host_watchdog_modbus_cmd_tb.sv]
// testbench: apb register access, ascii watchdog commands, rtu frames
// assumes the host model for the serial side and a short watchdog tick
`timescale 1ns/10ps
`default_nettype none
`include "wdt_cmd_cfg.svh"
module host_watchdog_modbus_cmd_tb;
	typedef wdt_cmd_pkg::byte_t bq_t[$];
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, rx_valid, rx_end, rx_err;
	logic tx_valid, tx_ready, protocol_rtu, nv_init_valid, nv_wr, other_func_req;
	logic [7:0] paddr, rx_data, tx_data, other_func_code, seen_code;
	logic [31:0] pwdata, prdata, r;
	logic [1:0] parity_sel;
	logic [3:0] baud_sel;
	logic [5:0] chan_fault;
	logic [9:0] nv_init_data, nv_wr_data, nv_last;
	logic e;
	int checks = 0;
	int n_mismatch = 0;
	bq_t f, none;
	// short tick keeps timeouts within a few hundred cycles
	host_watchdog_modbus_cmd #(.TICK_CYCLES(10)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_end(rx_end), .rx_err(rx_err), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .protocol_rtu(protocol_rtu),
		.parity_sel(parity_sel), .baud_sel(baud_sel), .chan_fault(chan_fault),
		.nv_init_valid(nv_init_valid), .nv_init_data(nv_init_data), .nv_wr(nv_wr),
		.nv_wr_data(nv_wr_data), .other_func_req(other_func_req),
		.other_func_code(other_func_code));
	host_link_model host (.pclk(pclk), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_end(rx_end), .rx_err(rx_err), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready));
	always #20 pclk = ~pclk;
	// remember the last stored watchdog state and the last handed-off function
	always @(posedge pclk) begin
		if (nv_wr === 1'b1)
			nv_last <= nv_wr_data;
		if (other_func_req === 1'b1)
			seen_code <= other_func_code;
	end
	task automatic results();
		$display("TB: %0d checks, %0d mismatches", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
		checks++;
		if (g !== x) begin
			n_mismatch++;
			$display("ERROR %0t: %s got %h exp %h", $time, m, g, x);
		end
	endtask
	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic bq_t s2q(input string s);
		bq_t q;
		for (int i = 0; i < s.len(); i++)
			q.push_back(s[i]);
		return q;
	endfunction
	// append the frame check, low byte first
	function automatic bq_t rtu(input bq_t b);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (b[i]) begin
			c = c ^ {8'h00, b[i]};
			repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
		end
		b.push_back(c[7:0]);
		b.push_back(c[15:8]);
		return b;
	endfunction
	// send a frame, wait for the reply, then a quiet spell to catch extra bytes
	task automatic xfer(input bq_t fr, input bq_t x, input bit err = 1'b0);
		int n;
		bit bad;
		host.got.delete();
		host.send(fr, err);
		n = 0;
		while (host.got.size() < x.size() && n < 400) begin
			@(posedge pclk);
			n++;
		end
		repeat (40) @(posedge pclk);
		bad = host.got.size() != x.size();
		foreach (x[i])
			if (!bad && host.got[i] !== x[i])
				bad = 1'b1;
		checks++;
		if (bad) begin
			n_mismatch++;
			$display("ERROR %0t: reply %p exp %p", $time, host.got, x);
		end
	endtask
	// hang guard, far beyond the roughly 1500 cycles the tests need
	initial begin
		#800000;
		n_mismatch++;
		results();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		chan_fault = 6'h00;
		nv_init_valid = 1'b0;
		nv_init_data = 10'h000;
		presetn = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		apb(0, `CFG_OFS, 32'h0);
		chk(r, 32'h0000_0001, "cfg reset");
		apb(1, `WDT_OFS, 32'hFFFF_FFFF);
		apb(0, `WDT_OFS, 32'h0);
		chk(r, 32'h0, "wdt read-only");
		apb(0, 8'h0C, 32'h0);
		chk({r[30:0], e}, 32'h1, "unmapped");
		$display("TB: test registers done");
		xfer(s2q("~010"), s2q("!0100\015"));
		xfer(s2q("~013140"), s2q("!01\015"));
		xfer(s2q("~012"), s2q("!01140\015"));
		xfer(s2q("~010"), s2q("!0180\015"));
		xfer(s2q("~020"), none);
		xfer(s2q("~010"), none, 1'b1);
		xfer(s2q("~0132FF"), s2q("?01\015"));
		xfer(s2q("~013108"), s2q("!01\015"));
		repeat (5) xfer(s2q("~**"), none);
		xfer(s2q("~010"), s2q("!0180\015"));
		repeat (100) @(posedge pclk);
		xfer(s2q("~010"), s2q("!0104\015"));
		apb(0, `WDT_OFS, 32'h0);
		chk(r, 32'h0000_0804, "wdt after timeout");
		chk(nv_last, 10'h108, "stored state");
		xfer(s2q("~012"), s2q("!01008\015"));
		host.slow = 1'b1;
		xfer(s2q("~011"), s2q("!01\015"));
		host.slow = 1'b0;
		xfer(s2q("~010"), s2q("!0100\015"));
		chk(nv_last, 10'h008, "stored after clear");
		// power cycle: state must come back from the stored copy
		nv_init_data <= 10'h140;
		nv_init_valid <= 1'b1;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		nv_init_valid <= 1'b0;
		apb(0, `WDT_OFS, 32'h0);
		chk(r, 32'h0000_4004, "reload after reset");
		xfer(s2q("~010"), s2q("!0104\015"));
		$display("TB: test ascii watchdog done");
		apb(1, `CFG_OFS, 32'h0000_1501);
		// settings land at the access edge; look one edge later
		@(posedge pclk);
		chk({protocol_rtu, parity_sel, baud_sel}, 32'h0000_0061, "line settings");
		apb(1, `CHAN_OFS, 32'h0000_003F);
		chan_fault <= 6'h25;
		apb(0, `CHAN_OFS, 32'h0);
		chk(r, 32'h0000_253F, "chan faults");
		xfer(rtu('{8'h01, 8'h02, 8'h00, 8'h80, 8'h00, 8'h06}),
			rtu('{8'h01, 8'h02, 8'h01, 8'h25}));
		xfer(rtu('{8'h01, 8'h02, 8'h00, 8'h82, 8'h00, 8'h03}),
			rtu('{8'h01, 8'h02, 8'h01, 8'h01}));
		xfer(rtu('{8'h01, 8'h02, 8'h00, 8'h86, 8'h00, 8'h01}), rtu('{8'h01, 8'h82, 8'h02}));
		xfer(rtu('{8'h01, 8'h02, 8'h00, 8'h81, 8'h00, 8'h06}), rtu('{8'h01, 8'h82, 8'h03}));
		xfer(rtu('{8'h01, 8'h02, 8'h00, 8'h80, 8'h00}), rtu('{8'h01, 8'h82, 8'h03}));
		xfer(rtu('{8'h01, 8'h03, 8'h00, 8'h80, 8'h00, 8'h01}), rtu('{8'h01, 8'h83, 8'h01}));
		f = rtu('{8'h01, 8'h02, 8'h00, 8'h80, 8'h00, 8'h01});
		f[6] = f[6] ^ 8'h01;
		xfer(f, none);
		xfer(rtu('{8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}), none);
		chk(seen_code, 32'h04, "handed-off function");
		$display("TB: test rtu done");
		results();
	end
endmodule
`default_nettype wire

// [logic/host_watchdog_modbus_cmd.sv]
// command front end: ascii host watchdog commands and rtu frame dispatch
// assumes an outside framer gives bytes, end-of-frame and error pulses
//
// Contract
// - status byte bit 7 shows watchdog enabled.
// - status byte bit 2 shows a timeout occurred; sent as two hex digits.
// - status kept nonvolatile; timeout flag cleared only by clear command.
// - no reply on bad syntax, communication error or foreign address.
// - accepted reply starts '!', rejected '?', then own address in hex.
// - command '1' clears timeout flag and acknowledges with address.
// - command '2' replies enable digit then two hex timeout digits.
// - timeout value is 8-bit count of 100 ms steps.
// - command '3' stores enable digit and timeout value.
// - a timeout disables the watchdog until set again.
// - host-alive broadcast accepted without any reply.
// - rtu characters are 8 data bits, rate selectable.
// - parity selectable only on newer variant, else none, one stop.
// - function codes 02, 04 and 46 are accepted.
// - unsupported function replies address, code OR 80, exception 01.
// - crc mismatch discards frame with no reply.
// - input status request: start 80..85, count 1..6, sum at most 86.
// - input status reply: byte count 1, bit per enabled faulty channel.
// - faulty input status request: code 82, exception 02 or 03.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_cmd_cfg.svh"
module host_watchdog_modbus_cmd #(
	parameter int TICK_CYCLES = `TICK_CYC,
	parameter bit PARITY_SELECTABLE = 1'b1
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// received bytes from the framer
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_end,
	input wire logic rx_err,
	// reply bytes to the framer
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	// line settings for the framer
	output logic protocol_rtu,
	output logic [1:0] parity_sel,
	output logic [3:0] baud_sel,
	// channel fault inputs
	input wire logic [5:0] chan_fault,
	// nonvolatile copy of the watchdog state
	input wire logic nv_init_valid,
	input wire logic [9:0] nv_init_data,
	output logic nv_wr,
	output logic [9:0] nv_wr_data,
	// functions handled elsewhere
	output logic other_func_req,
	output logic [7:0] other_func_code
);
	wdt_cmd_pkg::state_t state_ff;
	wdt_cmd_pkg::byte_t rx_buf_ff [0:7];
	wdt_cmd_pkg::byte_t tx_buf_ff [0:7];
	wdt_cmd_pkg::byte_t rep [0:7];
	logic [3:0] rx_cnt_ff, tx_len_ff, tx_idx_ff, rep_len;
	logic rx_bad_ff, rep_go, init_done_ff;
	logic [15:0] crc_ff, rep_crc;
	logic [7:0] addr_ff, wdt_val_ff, tenth_ff, stat_byte, tx_data_ff, mb_data, mb_mask;
	logic rtu_ff, wdt_en_ff, wdt_to_ff, nv_wr_ff, other_req_ff;
	logic [1:0] parity_ff;
	logic [3:0] baud_ff;
	logic [5:0] chan_en_ff, fault_bits;
	logic [21:0] tick_ff;
	logic [31:0] prdata_ff;
	logic [9:0] nv_data_ff;
	logic [7:0] other_code_ff;
	logic do_clear, do_set, set_en, host_ok, to_evt, tick_wrap, other_req;
	logic [7:0] set_val;
	logic nxt_wdt_en, nxt_wdt_to;
	logic [7:0] nxt_wdt_val;
	logic [4:0] h1, h2, h5, h6;
	logic [15:0] mb_n;
	logic [7:0] mb_sum;
	logic ap_wr, ap_setup, mapped, a_match;

	// nibble to upper-case ascii digit
	function automatic logic [7:0] hex_char(input logic [3:0] n);
		hex_char = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction

	// ascii digit to {valid, nibble}
	function automatic logic [4:0] hex_val(input logic [7:0] c);
		hex_val = 5'h00;
		if (c >= 8'h30 && c <= 8'h39) begin
			hex_val = {1'b1, c[3:0]};
		end else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) begin
			hex_val = {1'b1, 4'(c[3:0] + 4'h9)};
		end
	endfunction

	// reflected crc-16 step over one byte
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
		end
		crc_byte = r;
	endfunction

	// apb: zero wait, read data latched in the setup cycle
	assign pready = 1'b1;
	assign ap_setup = psel && !penable;
	assign ap_wr = psel && penable && pwrite;
	assign mapped = (paddr == `CFG_OFS) || (paddr == `WDT_OFS) || (paddr == `CHAN_OFS);
	assign pslverr = psel && penable && !mapped;
	assign prdata = prdata_ff;
	assign stat_byte = {wdt_en_ff, 4'h0, wdt_to_ff, 2'b00};
	assign fault_bits = chan_fault & chan_en_ff;

	// register read capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (ap_setup) begin
			prdata_ff <= 32'h0000_0000;
			unique case (paddr)
				`CFG_OFS: prdata_ff <= {16'h0000, baud_ff, 1'b0, parity_ff, rtu_ff, addr_ff};
				`WDT_OFS: prdata_ff <= {16'h0000, wdt_val_ff, stat_byte};
				`CHAN_OFS: prdata_ff <= {18'h00000, fault_bits, 2'b00, chan_en_ff};
				default: prdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	// software configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_ff <= `ADDR_RST;
			rtu_ff <= 1'b0;
			parity_ff <= 2'b00;
			baud_ff <= 4'h0;
			chan_en_ff <= 6'h00;
		end else if (ap_wr && paddr == `CFG_OFS) begin
			addr_ff <= pwdata[`CFG_ADDR_LSB +: 8];
			rtu_ff <= pwdata[`CFG_MODE_BIT];
			// fixed framing keeps parity none
			parity_ff <= PARITY_SELECTABLE ? pwdata[`CFG_PAR_LSB +: 2] : 2'b00;
			baud_ff <= pwdata[`CFG_BAUD_LSB +: 4];
		end else if (ap_wr && paddr == `CHAN_OFS) begin
			chan_en_ff <= pwdata[5:0];
		end
	end
	assign protocol_rtu = rtu_ff;
	assign parity_sel = parity_ff;
	assign baud_sel = baud_ff;

	// frame collection; bytes in exec or tx are dropped (half duplex)
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_cnt_ff <= 4'h0;
			rx_bad_ff <= 1'b0;
			crc_ff <= `CRC_INIT;
			for (int i = 0; i < 8; i++) begin
				rx_buf_ff[i] <= 8'h00;
			end
		end else if (state_ff == wdt_cmd_pkg::ST_EXEC) begin
			rx_cnt_ff <= 4'h0;
			rx_bad_ff <= 1'b0;
			crc_ff <= `CRC_INIT;
		end else if (state_ff == wdt_cmd_pkg::ST_RX) begin
			if (rx_err) begin
				rx_bad_ff <= 1'b1;
			end
			if (rx_valid) begin
				crc_ff <= crc_byte(crc_ff, rx_data);
				if (rx_cnt_ff < 4'h8) begin
					rx_buf_ff[rx_cnt_ff[2:0]] <= rx_data;
				end
				// count saturates at 9 meaning too long
				if (rx_cnt_ff < 4'h9) begin
					rx_cnt_ff <= rx_cnt_ff + 4'h1;
				end
			end
		end
	end

	assign h1 = hex_val(rx_buf_ff[1]);
	assign h2 = hex_val(rx_buf_ff[2]);
	assign h5 = hex_val(rx_buf_ff[5]);
	assign h6 = hex_val(rx_buf_ff[6]);
	assign a_match = h1[4] && h2[4] && ({h1[3:0], h2[3:0]} == addr_ff);
	assign mb_n = {rx_buf_ff[4], rx_buf_ff[5]};
	assign mb_sum = 8'(rx_buf_ff[3] + rx_buf_ff[5]);
	assign mb_mask = 8'((9'h001 << rx_buf_ff[5][2:0]) - 9'h001);
	assign mb_data = 8'({2'b00, fault_bits} >> rx_buf_ff[3][2:0]) & mb_mask;

	// command decode and reply build
	always_comb begin
		rep_go = 1'b0;
		rep_len = 4'h0;
		do_clear = 1'b0;
		do_set = 1'b0;
		set_en = 1'b0;
		set_val = 8'h00;
		host_ok = 1'b0;
		other_req = 1'b0;
		rep_crc = `CRC_INIT;
		for (int i = 0; i < 8; i++) begin
			rep[i] = 8'h00;
		end
		// rtu replies echo the function code after the address byte
		rep[1] = rtu_ff ? rx_buf_ff[1] : hex_char(addr_ff[7:4]);
		rep[2] = hex_char(addr_ff[3:0]);
		if (state_ff == wdt_cmd_pkg::ST_EXEC && !rx_bad_ff && rx_cnt_ff < 4'h9) begin
			if (!rtu_ff) begin
				rep[0] = `CH_OK;
				rep[3] = `CH_CR;
				rep_len = 4'h4;
				if (rx_cnt_ff == 4'h3 && rx_buf_ff[0] == `CH_TILDE
						&& rx_buf_ff[1] == `CH_STAR && rx_buf_ff[2] == `CH_STAR) begin
					host_ok = 1'b1;
				end else if (rx_buf_ff[0] == `CH_TILDE && a_match) begin
					if (rx_cnt_ff == 4'h4 && rx_buf_ff[3] == `CH_0) begin
						rep_go = 1'b1;
						rep[3] = hex_char(stat_byte[7:4]);
						rep[4] = hex_char(stat_byte[3:0]);
						rep[5] = `CH_CR;
						rep_len = 4'h6;
					end else if (rx_cnt_ff == 4'h4 && rx_buf_ff[3] == `CH_1) begin
						rep_go = 1'b1;
						do_clear = 1'b1;
					end else if (rx_cnt_ff == 4'h4 && rx_buf_ff[3] == `CH_2) begin
						rep_go = 1'b1;
						rep[3] = wdt_en_ff ? `CH_1 : `CH_0;
						rep[4] = hex_char(wdt_val_ff[7:4]);
						rep[5] = hex_char(wdt_val_ff[3:0]);
						rep[6] = `CH_CR;
						rep_len = 4'h7;
					end else if (rx_cnt_ff == 4'h7 && rx_buf_ff[3] == `CH_3) begin
						rep_go = 1'b1;
						// a bad enable digit or value is refused with '?'
						if ((rx_buf_ff[4] == `CH_0 || rx_buf_ff[4] == `CH_1) && h5[4] && h6[4]) begin
							do_set = 1'b1;
							set_en = rx_buf_ff[4][0];
							set_val = {h5[3:0], h6[3:0]};
						end else begin
							rep[0] = `CH_BAD;
						end
					end
				end
			end else if (crc_ff == 16'h0000 && rx_cnt_ff >= 4'h4 && rx_buf_ff[0] == addr_ff) begin
				rep_go = 1'b1;
				rep[0] = addr_ff;
				rep_len = 4'h5;
				if (rx_buf_ff[1] == `FC_STAT) begin
					rep_len = 4'h6;
					rep[2] = 8'h01;
					rep[3] = mb_data;
					if (rx_cnt_ff != `STAT_REQ_LEN) begin
						rep_len = 4'h5;
						rep[1] = `FC_STAT | `FC_EXC;
						rep[2] = `EX_RANGE;
					end else if (rx_buf_ff[2] != 8'h00 || rx_buf_ff[3] < `CH_BASE
							|| rx_buf_ff[3] > `CH_LAST) begin
						rep_len = 4'h5;
						rep[1] = `FC_STAT | `FC_EXC;
						rep[2] = `EX_START;
					end else if (mb_n == 16'h0000 || mb_n > {8'h00, `CH_MAX}
							|| mb_sum > `CH_END) begin
						rep_len = 4'h5;
						rep[1] = `FC_STAT | `FC_EXC;
						rep[2] = `EX_RANGE;
					end
				end else if (rx_buf_ff[1] == `FC_CHAN || rx_buf_ff[1] == `FC_SET) begin
					rep_go = 1'b0;
					other_req = 1'b1;
				end else begin
					rep[1] = rx_buf_ff[1] | `FC_EXC;
					rep[2] = `EX_FUNC;
				end
				for (int i = 0; i < 4; i++) begin
					if (4'(i) < 4'(rep_len - 4'h2)) begin
						rep_crc = crc_byte(rep_crc, rep[i]);
					end
				end
				if (rep_len == 4'h5) begin
					rep[3] = rep_crc[7:0];
					rep[4] = rep_crc[15:8];
				end else begin
					rep[4] = rep_crc[7:0];
					rep[5] = rep_crc[15:8];
				end
			end
		end
	end

	// sequencing and reply shifting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= wdt_cmd_pkg::ST_RX;
			tx_len_ff <= 4'h0;
			tx_idx_ff <= 4'h0;
			tx_data_ff <= 8'h00;
			for (int i = 0; i < 8; i++) begin
				tx_buf_ff[i] <= 8'h00;
			end
		end else begin
			unique case (state_ff)
				wdt_cmd_pkg::ST_RX: begin
					if (rx_end) begin
						state_ff <= wdt_cmd_pkg::ST_EXEC;
					end
				end
				wdt_cmd_pkg::ST_EXEC: begin
					if (rep_go) begin
						state_ff <= wdt_cmd_pkg::ST_TX;
						tx_buf_ff <= rep;
						tx_len_ff <= rep_len;
						tx_idx_ff <= 4'h0;
						tx_data_ff <= rep[0];
					end else begin
						state_ff <= wdt_cmd_pkg::ST_RX;
					end
				end
				wdt_cmd_pkg::ST_TX: begin
					if (tx_ready) begin
						if (tx_idx_ff == 4'(tx_len_ff - 4'h1)) begin
							state_ff <= wdt_cmd_pkg::ST_RX;
						end else begin
							tx_idx_ff <= tx_idx_ff + 4'h1;
							tx_data_ff <= tx_buf_ff[3'(tx_idx_ff + 4'h1)];
						end
					end
				end
			endcase
		end
	end
	assign tx_valid = (state_ff == wdt_cmd_pkg::ST_TX);
	assign tx_data = tx_data_ff;

	// 100 ms tick and tenths count; restarts on alive, set, or while off
	assign tick_wrap = (tick_ff == 22'(TICK_CYCLES - 1));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_ff <= 22'h000000;
			tenth_ff <= 8'h00;
		end else if (host_ok || do_set || !wdt_en_ff) begin
			tick_ff <= 22'h000000;
			tenth_ff <= 8'h00;
		end else if (tick_wrap) begin
			tick_ff <= 22'h000000;
			tenth_ff <= 8'(tenth_ff + 8'h01);
		end else begin
			tick_ff <= tick_ff + 22'h000001;
		end
	end
	// a value of 00 never expires
	assign to_evt = wdt_en_ff && !host_ok && !do_set && tick_wrap
		&& wdt_val_ff != 8'h00 && 8'(tenth_ff + 8'h01) == wdt_val_ff;

	// watchdog state; timeout beats a clear in the same cycle
	always_comb begin
		nxt_wdt_en = do_set ? set_en : wdt_en_ff;
		nxt_wdt_val = do_set ? set_val : wdt_val_ff;
		nxt_wdt_to = wdt_to_ff;
		if (do_clear) begin
			nxt_wdt_to = 1'b0;
		end
		if (to_evt) begin
			nxt_wdt_to = 1'b1;
			nxt_wdt_en = 1'b0;
		end
	end

	// state store, loaded once from the nonvolatile copy after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_done_ff <= 1'b0;
			wdt_en_ff <= 1'b0;
			wdt_to_ff <= 1'b0;
			wdt_val_ff <= 8'h00;
			nv_wr_ff <= 1'b0;
			nv_data_ff <= 10'h000;
		end else if (!init_done_ff) begin
			init_done_ff <= 1'b1;
			if (nv_init_valid) begin
				{wdt_en_ff, wdt_to_ff, wdt_val_ff} <= nv_init_data;
				nv_data_ff <= nv_init_data;
			end
		end else begin
			wdt_en_ff <= nxt_wdt_en;
			wdt_to_ff <= nxt_wdt_to;
			wdt_val_ff <= nxt_wdt_val;
			// write back only on change to spare the storage
			nv_wr_ff <= {nxt_wdt_en, nxt_wdt_to, nxt_wdt_val} != {wdt_en_ff, wdt_to_ff, wdt_val_ff};
			nv_data_ff <= {nxt_wdt_en, nxt_wdt_to, nxt_wdt_val};
		end
	end
	assign nv_wr = nv_wr_ff;
	assign nv_wr_data = nv_data_ff;

	// hand-off of functions served elsewhere
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			other_req_ff <= 1'b0;
			other_code_ff <= 8'h00;
		end else begin
			other_req_ff <= other_req;
			if (other_req) begin
				other_code_ff <= rx_buf_ff[1];
			end
		end
	end
	assign other_func_req = other_req_ff;
	assign other_func_code = other_code_ff;

	// checks
	a_timeout_disables: assert property (@(posedge pclk) disable iff (!presetn)
		to_evt |=> wdt_to_ff && !wdt_en_ff && nv_wr) else $error("timeout did not disable");
	a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		init_done_ff && wdt_to_ff && !do_clear |=> wdt_to_ff) else $error("flag lost");
	a_crc_silent: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == wdt_cmd_pkg::ST_EXEC && rtu_ff && crc_ff != 16'h0000
		|=> state_ff == wdt_cmd_pkg::ST_RX) else $error("reply to bad crc");
	a_foreign_silent: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == wdt_cmd_pkg::ST_EXEC && !rtu_ff && !a_match
		|=> !tx_valid [*2]) else $error("reply to foreign address");
	a_reply_mark: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(tx_valid) && !rtu_ff |-> (tx_data == `CH_OK || tx_data == `CH_BAD)
		&& tx_buf_ff[1] == hex_char(addr_ff[7:4])) else $error("bad reply head");
	a_status_digits: assert property (@(posedge pclk) disable iff (!presetn)
		state_ff == wdt_cmd_pkg::ST_EXEC && rep_go && !rtu_ff && rx_buf_ff[3] == `CH_0
		|=> tx_buf_ff[3] == hex_char({$past(wdt_en_ff), 3'b000})
		&& tx_buf_ff[4] == hex_char({1'b0, $past(wdt_to_ff), 2'b00})) else $error("status");
	a_func_except: assert property (@(posedge pclk) disable iff (!presetn)
		rep_go && rtu_ff && rx_buf_ff[1] != `FC_STAT
		|=> tx_buf_ff[1] == ($past(rx_buf_ff[1]) | `FC_EXC) && tx_buf_ff[2] == `EX_FUNC
		&& tx_len_ff == 4'h5) else $error("bad exception");
	a_start_range: assert property (@(posedge pclk) disable iff (!presetn)
		rep_go && rtu_ff && rx_buf_ff[1] == `FC_STAT && rx_cnt_ff == `STAT_REQ_LEN
		&& rx_buf_ff[3] > `CH_LAST |=> tx_buf_ff[2] == `EX_START) else $error("start");
	a_alive_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		host_ok |=> state_ff == wdt_cmd_pkg::ST_RX && tick_ff == 22'h000000) else $error("alive");
endmodule
`default_nettype wire

// [logic/wdt_cmd_cfg.svh]
// constants of the watchdog and field-bus command front end
// assumes nothing; included by the top module and the bench
`ifndef WDT_CMD_CFG_SVH
`define WDT_CMD_CFG_SVH
`define CFG_OFS 8'h00
`define WDT_OFS 8'h04
`define CHAN_OFS 8'h08
`define ADDR_RST 8'h01
`define CFG_ADDR_LSB 0
`define CFG_MODE_BIT 8
`define CFG_PAR_LSB 9
`define CFG_BAUD_LSB 12
`define CHAN_FAULT_LSB 8
`define WDT_VAL_LSB 8
`define EN_BIT 7
`define TO_BIT 2
`define TICK_MS 100
`define CLK_KHZ 25000
`define TICK_CYC (`TICK_MS * `CLK_KHZ)
`define CH_TILDE 8'h7E
`define CH_STAR 8'h2A
`define CH_OK 8'h21
`define CH_BAD 8'h3F
`define CH_CR 8'h0D
`define CH_0 8'h30
`define CH_1 8'h31
`define CH_2 8'h32
`define CH_3 8'h33
`define FC_STAT 8'h02
`define FC_CHAN 8'h04
`define FC_SET 8'h46
`define FC_EXC 8'h80
`define EX_FUNC 8'h01
`define EX_START 8'h02
`define EX_RANGE 8'h03
`define CH_BASE 8'h80
`define CH_LAST 8'h85
`define CH_END 8'h86
`define CH_MAX 8'h06
`define STAT_REQ_LEN 4'h8
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001
`endif

// [logic/wdt_cmd_pkg.sv]
// types of the watchdog and field-bus command front end
// assumes the cfg header for constants
package wdt_cmd_pkg;
	typedef enum logic [2:0] {
		ST_RX = 3'b001,
		ST_EXEC = 3'b010,
		ST_TX = 3'b100
	} state_t;
	typedef logic [7:0] byte_t;
endpackage
